// ---- rtl/dma_channel_start_arbitration.sv ----
// Eight-channel DMA request latching, manual start and fixed-priority arbiter
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module dma_channel_start_arbitration
    import dma_arb_pkg::*;
#(
    parameter int N_SRC = 2**SRC_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [N_SRC-1:0] periph_req,
    input wire logic xfer_done,
    output logic grant_valid,
    output logic [CH_W-1:0] grant_chan,
    output logic grant_dir,
    output logic grant_zero_write,
    output logic grant_buf,
    output logic [CNT_W-1:0] grant_count,
    output logic grant_forced
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [CH_W-1:0] prio_pick(input logic [N_CH-1:0] v);
        logic [CH_W-1:0] r;
        r = '0;
        for (int k = N_CH - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = CH_W'(k);
            end
        end
        return r;
    endfunction

    function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int ch, input logic [3:0] ofs);
        return !a[GLOBAL_BIT] && a[GLOBAL_BIT-1:CH_LSB] == CH_W'(ch) && a[CH_LSB-1:0] == ofs;
    endfunction

    // ---------------------------------------------------------------
    // Avalon slave handshake
    // ---------------------------------------------------------------
    logic ack;
    logic wr_fire;
    logic rd_fire;
    logic glob_ovr_wr;
    logic [DATA_W-1:0] rd_mux;

    // One wait state; the write lands on the edge that sees waitrequest low
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_fire = avs_write & ack;
    assign rd_fire = avs_read & ~ack;
    assign glob_ovr_wr = wr_fire && avs_address[GLOBAL_BIT] && avs_address[GLOBAL_BIT-1:0] == OFS_OVERRUN;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // ---------------------------------------------------------------
    // Channel state
    // ---------------------------------------------------------------
    arb_state_e state;
    logic [CH_W-1:0] cur;
    logic [CH_W-1:0] last_ch;
    logic done_fire;
    logic [N_CH-1:0] en, dir, zw, force_req, pend, ovr, buf_sel, want;
    logic [SRC_W-1:0] src_sel [N_CH];
    logic [CNT_W-1:0] cnt [N_CH];
    logic [CNT_W-1:0] lim [N_CH];

    assign done_fire = state == ARB_BUSY && xfer_done;
    assign want = (pend | force_req) & en;

    for (genvar i = 0; i < N_CH; i++) begin : g_ch
        logic ctrl_wr, req_wr, cnt_wr, reen, hit, done_me, force_set;
        logic en_r, dir_r, zw_r, force_r, pend_r, ovr_r, buf_r;
        logic [SRC_W-1:0] src_r;
        logic [CNT_W-1:0] cnt_r, lim_r;

        assign ctrl_wr = wr_fire && ch_hit(avs_address, i, OFS_CTRL);
        assign req_wr = wr_fire && ch_hit(avs_address, i, OFS_REQSEL);
        assign cnt_wr = wr_fire && ch_hit(avs_address, i, OFS_COUNT);
        assign reen = ctrl_wr && avs_writedata[CTRL_EN_BIT] && !en_r;
        assign done_me = done_fire && cur == CH_W'(i);
        // Disabled channels drop source pulses entirely
        assign hit = en_r && periph_req[src_r];
        // Ignored while this channel is mid-transfer or a peripheral request waits
        assign force_set = req_wr && avs_writedata[REQ_FORCE_BIT] && en_r && !pend_r
            && !(state == ARB_BUSY && cur == CH_W'(i));

        // -----------------------------------------------------------
        // Control register
        // -----------------------------------------------------------
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                en_r <= 1'b0;
                dir_r <= 1'b0;
                zw_r <= 1'b0;
            end else if (ctrl_wr) begin
                en_r <= avs_writedata[CTRL_EN_BIT];
                dir_r <= avs_writedata[CTRL_DIR_BIT];
                zw_r <= avs_writedata[CTRL_ZW_BIT];
            end
        end

        // -----------------------------------------------------------
        // Request source select
        // -----------------------------------------------------------
        // Source index takes effect on the next cycle; a pulse in the
        // same cycle as the write is judged against the old source
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                src_r <= '0;
            end else if (req_wr) begin
                src_r <= avs_writedata[SRC_W-1:0];
            end
        end

        // -----------------------------------------------------------
        // Latched peripheral request
        // -----------------------------------------------------------
        // Disabling drops the latch, so a stale request cannot fire
        // after the channel is set up again
        // New request wins over the clear at completion
        always_ff @(posedge clk_sys) begin
            if (!nrst || !en_r) begin
                pend_r <= 1'b0;
            end else if (hit) begin
                pend_r <= 1'b1;
            end else if (done_me) begin
                pend_r <= 1'b0;
            end
        end

        // -----------------------------------------------------------
        // Manual request
        // -----------------------------------------------------------
        // Software writing zero has no effect on the manual bit
        always_ff @(posedge clk_sys) begin
            if (!nrst || !en_r) begin
                force_r <= 1'b0;
            end else if (force_set) begin
                force_r <= 1'b1;
            end else if (done_me) begin
                force_r <= 1'b0;
            end
        end

        // -----------------------------------------------------------
        // Overrun flag
        // -----------------------------------------------------------
        // A repeat in the completion cycle re-latches instead; the
        // earlier word has just been moved, so nothing is lost
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                ovr_r <= 1'b0;
            // Set wins over a clear in the same cycle
            end else if (hit && pend_r && !done_me) begin
                ovr_r <= 1'b1;
            end else if (glob_ovr_wr && avs_writedata[i]) begin
                ovr_r <= 1'b0;
            end
        end

        // -----------------------------------------------------------
        // Transfer count and active buffer
        // -----------------------------------------------------------
        // Limit compare on equality: a limit written below the running
        // count lets the count wrap through the full range first
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                cnt_r <= '0;
                lim_r <= '0;
                buf_r <= 1'b0;
            end else begin
                if (cnt_wr) begin
                    lim_r <= avs_writedata[COUNT_LIM_LSB +: CNT_W];
                end
                if (reen) begin
                    cnt_r <= '0;
                    buf_r <= 1'b0;
                end else if (done_me) begin
                    if (cnt_r == lim_r) begin
                        cnt_r <= '0;
                        buf_r <= ~buf_r;
                    end else begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                end
            end
        end

        // -----------------------------------------------------------
        // Flattened views for arbiter and read path
        // -----------------------------------------------------------
        assign en[i] = en_r;
        assign dir[i] = dir_r;
        assign zw[i] = zw_r;
        assign force_req[i] = force_r;
        assign pend[i] = pend_r;
        assign ovr[i] = ovr_r;
        assign buf_sel[i] = buf_r;
        assign src_sel[i] = src_r;
        assign cnt[i] = cnt_r;
        assign lim[i] = lim_r;
    end

    // ---------------------------------------------------------------
    // Arbiter
    // ---------------------------------------------------------------
    logic [CH_W-1:0] next_ch;

    assign next_ch = prio_pick(want);

    // One transfer at a time; winner chosen fresh every idle cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ARB_IDLE;
            cur <= '0;
            last_ch <= '0;
            grant_valid <= 1'b0;
            grant_chan <= '0;
            grant_dir <= 1'b0;
            grant_zero_write <= 1'b0;
            grant_buf <= 1'b0;
            grant_count <= '0;
            grant_forced <= 1'b0;
        end else begin
            case (state)
                ARB_IDLE: begin
                    if (|want) begin
                        state <= ARB_BUSY;
                        cur <= next_ch;
                        grant_valid <= 1'b1;
                        grant_chan <= next_ch;
                        grant_dir <= dir[next_ch];
                        // Zero write only when reading the peripheral
                        grant_zero_write <= zw[next_ch] & ~dir[next_ch];
                        grant_buf <= buf_sel[next_ch];
                        grant_count <= cnt[next_ch];
                        // Peripheral request takes precedence over the manual one
                        grant_forced <= force_req[next_ch] & ~pend[next_ch];
                    end
                end
                ARB_BUSY: begin
                    if (xfer_done) begin
                        state <= ARB_IDLE;
                        last_ch <= cur;
                        grant_valid <= 1'b0;
                        grant_zero_write <= 1'b0;
                        grant_forced <= 1'b0;
                    end
                end
                default: begin
                    state <= ARB_IDLE;
                    grant_valid <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Registered read data: latched in the wait-state cycle, so it
    // stands on the edge at which waitrequest is sampled low
    logic [CH_W-1:0] rch;

    assign rch = avs_address[GLOBAL_BIT-1:CH_LSB];

    always_comb begin
        rd_mux = '0;
        if (avs_address[GLOBAL_BIT]) begin
            case (avs_address[GLOBAL_BIT-1:0])
                OFS_OVERRUN: rd_mux[N_CH-1:0] = ovr;
                OFS_LAST: begin
                    rd_mux[CH_W-1:0] = last_ch;
                    rd_mux[LAST_BUSY_BIT] = state == ARB_BUSY;
                end
                default: rd_mux = '0;
            endcase
        end else begin
            case (avs_address[CH_LSB-1:0])
                OFS_CTRL: begin
                    rd_mux[CTRL_EN_BIT] = en[rch];
                    rd_mux[CTRL_DIR_BIT] = dir[rch];
                    rd_mux[CTRL_ZW_BIT] = zw[rch];
                end
                OFS_REQSEL: begin
                    rd_mux[REQ_FORCE_BIT] = force_req[rch];
                    rd_mux[SRC_W-1:0] = src_sel[rch];
                end
                OFS_COUNT: begin
                    rd_mux[COUNT_LIM_LSB +: CNT_W] = lim[rch];
                    rd_mux[CNT_W-1:0] = cnt[rch];
                end
                OFS_STAT: begin
                    rd_mux[STAT_PEND_BIT] = pend[rch];
                    rd_mux[STAT_BUF_BIT] = buf_sel[rch];
                    rd_mux[STAT_FORCE_BIT] = force_req[rch];
                end
                default: rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            avs_readdata <= '0;
        end else if (rd_fire) begin
            avs_readdata <= rd_mux;
        end
    end
endmodule

// ---- rtl/dma_arb_pkg.sv ----
// Constants, register layout and types of the DMA start and arbitration block
package dma_arb_pkg;
    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int N_CH = 8;
    localparam int CH_W = 3;
    localparam int SRC_W = 7;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // ---------------------------------------------------------------
    // Address map: channel region, then global region
    // ---------------------------------------------------------------
    localparam int GLOBAL_BIT = 7;
    localparam int CH_LSB = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_REQSEL = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;
    localparam logic [6:0] OFS_OVERRUN = 7'h00;
    localparam logic [6:0] OFS_LAST = 7'h04;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_EN_BIT = 15;
    localparam int CTRL_DIR_BIT = 13;
    localparam int CTRL_ZW_BIT = 11;
    localparam int REQ_FORCE_BIT = 15;
    localparam int COUNT_LIM_LSB = 16;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_BUF_BIT = 1;
    localparam int STAT_FORCE_BIT = 2;
    localparam int LAST_BUSY_BIT = 8;
    // Code that selects the first serial interface as request source
    localparam logic [SRC_W-1:0] SRC_SERIAL0 = 7'h0a;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic {ARB_IDLE, ARB_BUSY} arb_state_e;
endpackage

// ---- test/dma_arb_properties.sv ----
// Concurrent checks on the ports of the DMA start and arbitration block
`timescale 1ns/10ps
module dma_arb_properties
    import dma_arb_pkg::*;
#(
    parameter int N_SRC = 2**SRC_W
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [N_SRC-1:0] periph_req,
    input wire logic xfer_done,
    input wire logic grant_valid,
    input wire logic [CH_W-1:0] grant_chan,
    input wire logic grant_dir,
    input wire logic grant_zero_write,
    input wire logic grant_buf,
    input wire logic [CNT_W-1:0] grant_count,
    input wire logic grant_forced
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----
    // Steps of an access and of a transfer
    // ----
    sequence s_access;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_busy;
        grant_valid && !xfer_done;
    endsequence
    sequence s_done;
        grant_valid && xfer_done;
    endsequence
    a_wait_once: assert property (s_access |=> !avs_waitrequest)
        else $error("waitrequest held past one wait state");
    a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high without an access");
    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_grant_hold: assert property (s_busy |=> grant_valid && $stable(grant_chan))
        else $error("grant moved before completion");
    a_grant_fields: assert property (s_busy |=> $stable({grant_dir, grant_zero_write, grant_buf, grant_count, grant_forced}))
        else $error("grant qualifiers changed mid transfer");
    a_done_release: assert property (s_done |=> !grant_valid)
        else $error("grant not released after completion");
    a_zero_dir: assert property (grant_valid && grant_zero_write |-> !grant_dir)
        else $error("zero write on a write to the peripheral");
    // Reset itself must not mask this one
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !grant_valid && avs_readdata == '0)
        else $error("outputs not cleared by reset");
endmodule

// ---- test/mover_model.sv ----
// Data mover model that ends each granted transfer after a set delay
`timescale 1ns/10ps
module mover_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic grant_valid,
    input wire logic [3:0] latency,
    output logic xfer_done
);
    logic [3:0] waited;
    // Single pulse; the guard stops a second one while grant drops
    always_ff @(posedge clk_sys) begin
        if (!nrst || !grant_valid) begin
            waited <= 4'h0;
            xfer_done <= 1'b0;
        end else begin
            waited <= waited + 4'h1;
            xfer_done <= (waited == latency) && !xfer_done;
        end
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the DMA start and arbitration block
`timescale 1ns/10ps
module tb;
    import dma_arb_pkg::*;
    localparam int NS = 2**SRC_W;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata, rd;
    logic avs_waitrequest, xfer_done, grant_valid, grant_dir, grant_zero_write, grant_buf, grant_forced;
    logic [NS-1:0] periph_req = '0;
    logic [3:0] latency = 4'h1;
    logic [CH_W-1:0] grant_chan;
    logic [CNT_W-1:0] grant_count;
    logic [N_CH-1:0] pend;
    logic [N_CH-1:0] ovr = '0;
    logic [1:0] cfg [N_CH];
    int cnt [N_CH];
    int errors = 0;
    int checks_done = 0;
    int e, k, r, first;
    always #2 clk_sys = ~clk_sys;
    dma_channel_start_arbitration #(.N_SRC(NS)) DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .periph_req(periph_req), .xfer_done(xfer_done),
        .grant_valid(grant_valid), .grant_chan(grant_chan), .grant_dir(grant_dir),
        .grant_zero_write(grant_zero_write), .grant_buf(grant_buf), .grant_count(grant_count),
        .grant_forced(grant_forced));
    mover_model mover (.clk_sys(clk_sys), .nrst(nrst), .grant_valid(grant_valid), .latency(latency),
        .xfer_done(xfer_done));
    // ----
    // Helpers
    // ----
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [SRC_W-1:0] src(int c);
        return SRC_SERIAL0 + SRC_W'(c * 5);
    endfunction
    function automatic logic [ADDR_W-1:0] ra(int c, logic [3:0] o);
        return ADDR_W'(c * 16) | ADDR_W'(o);
    endfunction
    function automatic int lowest(logic [N_CH-1:0] m);
        for (int c = 0; c < N_CH; c++) if (m[c]) return c;
        return 0;
    endfunction
    function automatic logic [31:0] ctrl(int c);
        return 32'h8000 | 32'(cfg[c][1]) << 13 | 32'(cfg[c][0]) << 11;
    endfunction
    task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Request stands until the rising edge that samples waitrequest low
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            errors++;
            wrap_up();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic pulse(logic [N_CH-1:0] m);
        @(posedge clk_sys);
        for (int c = 0; c < N_CH; c++) if (m[c]) periph_req[src(c)] <= 1'b1;
        @(posedge clk_sys);
        periph_req <= '0;
    endtask
    task automatic take(int ch, logic frc, int idle);
        int n;
        for (n = 0; n < 60 && grant_valid !== 1'b1; n++) @(negedge clk_sys);
        if (n == 60) begin
            errors++;
            wrap_up();
        end
        if (idle != 0) chk("grant delay", 2, n);
        chk("grant", 32'({3'(ch), cfg[ch][1], cfg[ch][0] & ~cfg[ch][1], 1'b0, 10'(cnt[ch]), frc}),
            32'({grant_chan, grant_dir, grant_zero_write, grant_buf, grant_count, grant_forced}));
        cnt[ch]++;
    endtask
    task automatic settle();
        int n;
        for (n = 0; n < 60 && grant_valid !== 1'b0; n++) @(negedge clk_sys);
        if (n == 60) begin
            errors++;
            wrap_up();
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'haffd));
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b1, 8'h90, 32'hffffffff);
        bus(1'b0, 8'h90, '0);
        chk("unmapped", 0, rd);
        for (k = 0; k < N_CH; k++) begin
            cfg[k] = 2'($urandom);
            cnt[k] = 0;
            bus(1'b1, ra(k, OFS_COUNT), 32'h03ff0000);
            bus(1'b1, ra(k, OFS_REQSEL), 32'(src(k)));
            pulse(N_CH'(1 << k));
            bus(1'b1, ra(k, OFS_CTRL), ctrl(k));
            bus(1'b0, ra(k, OFS_STAT), '0);
            chk("stat", 0, rd);
        end
        for (r = 0; r < 40; r++) begin
            latency <= 4'(1 + $urandom % 6);
            pend = N_CH'($urandom);
            if (pend == 0) pend = 8'h80;
            pulse(pend);
            first = 1;
            while (pend != 0) begin
                e = lowest(pend);
                take(e, 1'b0, first);
                pend[e] = 1'b0;
                if (first == 1) begin
                    k = $urandom % N_CH;
                    if (k != e) begin
                        ovr[k] = ovr[k] | pend[k];
                        pend[k] = 1'b1;
                        pulse(N_CH'(1 << k));
                    end
                end
                first = 0;
                settle();
            end
        end
        bus(1'b0, 8'h80, '0);
        chk("overrun", 32'(ovr), rd);
        bus(1'b1, 8'h80, 32'hff);
        bus(1'b0, 8'h80, '0);
        chk("overrun", 0, rd);
        // Forced start with the quickest possible completion
        e = $urandom % N_CH;
        latency <= 4'h0;
        bus(1'b1, ra(e, OFS_REQSEL), 32'h8000 | 32'(src(e)));
        take(e, 1'b1, 0);
        settle();
        bus(1'b0, ra(e, OFS_REQSEL), '0);
        chk("manual", 32'(src(e)), rd);
        chk("extra grant", 0, 32'(grant_valid));
        bus(1'b0, ra(e, OFS_COUNT), '0);
        chk("count", 32'h03ff0000 | 32'(cnt[e]), rd);
        bus(1'b1, ra(e, OFS_CTRL), '0);
        bus(1'b1, ra(e, OFS_REQSEL), 32'h8000 | 32'(src(e)));
        pulse(N_CH'(1 << e));
        bus(1'b1, ra(e, OFS_CTRL), ctrl(e));
        cnt[e] = 0;
        bus(1'b0, ra(e, OFS_COUNT), '0);
        chk("count", 32'h03ff0000, rd);
        bus(1'b0, ra(e, OFS_STAT), '0);
        chk("stat", 0, rd);
        pulse(N_CH'(1 << e));
        take(e, 1'b0, 1);
        settle();
        wrap_up();
    end
endmodule
bind dma_channel_start_arbitration dma_arb_properties #(.N_SRC(N_SRC)) chk_i (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .periph_req(periph_req),
    .xfer_done(xfer_done), .grant_valid(grant_valid), .grant_chan(grant_chan), .grant_dir(grant_dir),
    .grant_zero_write(grant_zero_write), .grant_buf(grant_buf), .grant_count(grant_count),
    .grant_forced(grant_forced));
